//--- pkg/ptc_pkg.sv
/*
 Constants, field layout and state type of the pulse timer cell.
 Assumes a single 50 MHz system clock and software control over APB.
*/

package ptc_pkg;

	// ================================================================
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TB_10MS_NS    = 10_000_000;
	localparam int unsigned TICK_10MS_CYC = TB_10MS_NS / CLK_PERIOD_NS;
	localparam int unsigned MAX_DUR_S     = 9990;
	localparam int unsigned BASE_STAGES   = 4;

	// ================================================================
	// Timer word layout.
	localparam int unsigned DIGITS   = 3;
	localparam int unsigned READ_W   = 12;
	localparam int unsigned BASE_LO  = 12;
	localparam int unsigned BASE_HI  = 13;
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned BIN_W    = 10;
	localparam logic [1:0]  BASE_10MS  = 2'h0;
	localparam logic [1:0]  BASE_100MS = 2'h1;
	localparam logic [1:0]  BASE_1S    = 2'h2;
	localparam logic [1:0]  BASE_10S   = 2'h3;

	// ================================================================
	// Register map, byte offsets and reset values.
	localparam int unsigned APB_AW      = 8;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_PRELOAD = 8'h04;
	localparam logic [7:0]  OFS_STATUS  = 8'h08;
	localparam logic [7:0]  OFS_TIME    = 8'h0c;
	localparam logic [7:0]  OFS_REMAIN  = 8'h10;
	localparam int unsigned CTRL_TRIG   = 0;
	localparam int unsigned CTRL_KILL   = 1;
	localparam int unsigned CTRL_EXT    = 2;
	localparam logic [2:0]  CTRL_RST    = 3'h0;
	localparam logic [13:0] PRELOAD_RST = 14'h0000;

	// Timer state.
	typedef enum logic {PT_IDLE, PT_RUN} ptc_state_t;

endpackage : ptc_pkg

//--- design/ptc_tick_gen.sv
/*
 Time-base tick generator: one-cycle pulses at 10 ms, 100 ms, 1 s, 10 s.
 Assumes the system clock; the 10 ms count is a parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module ptc_tick_gen #(
	parameter int unsigned TICK_10MS_CYC = ptc_pkg::TICK_10MS_CYC
) (
	// Clock and reset.
	input  wire logic                           sys_clk,
	input  wire logic                           srst,
	// Tick pulses, index is the base code.
	output logic [ptc_pkg::BASE_STAGES-1:0]     tick
);
	import ptc_pkg::*;

	// Refuse a prescaler the counter cannot serve.
	if (TICK_10MS_CYC < 2) begin : g_chk
		$error("TICK_10MS_CYC must be at least 2");
	end

	logic [31:0] pre_q;  // Prescaler for the 10 ms base.

	// Prescaler wraps once per 10 ms.
	always_ff @(posedge sys_clk) begin
		if (srst || pre_q == TICK_10MS_CYC - 1)
			pre_q <= 32'h0;
		else
			pre_q <= pre_q + 32'h1;
	end
	assign tick[0] = (pre_q == TICK_10MS_CYC - 1);

	for (genvar i = 1; i < BASE_STAGES; i++) begin : g_dec
		logic [3:0] dec_q;  // Decade counter of this stage.
		always_ff @(posedge sys_clk) begin
			if (srst)
				dec_q <= 4'h0;
			else if (tick[i-1])
				dec_q <= (dec_q == 4'h9) ? 4'h0 : dec_q + 4'h1;
		end
		assign tick[i] = tick[i-1] && (dec_q == 4'h9);
		// Each slower tick coincides with a faster one.
		tick_nest_a: assert property (@(posedge sys_clk) disable iff (srst)
			tick[i] |-> tick[i-1])
			else $error("slower tick without faster tick");
	end

endmodule : ptc_tick_gen
`default_nettype wire

//--- design/ptc_bcd_bin.sv
/*
 Registered three-digit BCD to binary converter for the remaining count.
 Assumes digits already hold values 0 to 9.
*/
`timescale 1ns/1ps
`default_nettype none

module ptc_bcd_bin (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          srst,
	// BCD reading in, binary word out.
	input  wire logic [ptc_pkg::READ_W-1:0]    bcd,
	output logic      [ptc_pkg::WORD_W-1:0]    bin_q
);
	import ptc_pkg::*;

	logic [WORD_W-1:0] sum;  // Weighted sum of digits.

	always_comb begin
		sum = 16'(bcd[3:0]) + 16'(bcd[7:4]) * 16'h000a + 16'(bcd[11:8]) * 16'h0064;
	end

	// One register stage keeps the output glitch free.
	always_ff @(posedge sys_clk) begin
		if (srst)
			bin_q <= 16'h0000;
		else
			bin_q <= sum;
	end

	// Binary word follows the reading one cycle later.
	bin_track_a: assert property (@(posedge sys_clk) disable iff (srst)
		##1 bin_q == 16'($past(bcd[3:0])) + 16'($past(bcd[7:4])) * 16'h000a
			+ 16'($past(bcd[11:8])) * 16'h0064)
		else $error("binary count does not match BCD reading");

endmodule : ptc_bcd_bin
`default_nettype wire

//--- design/ptc_top.sv
/*
 Pulse timer cell with pulse and extended pulse modes, APB controlled.
 Assumes an APB master on sys_clk; trigger and kill come from software.
*/
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ptc_top #(
	parameter int unsigned TICK_10MS_CYC = ptc_pkg::TICK_10MS_CYC
) (
	// Clock and reset.
	input  wire logic                         sys_clk,
	input  wire logic                         srst,
	// APB slave.
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [ptc_pkg::APB_AW-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Timer results.
	output logic                              pulse_out,
	output logic      [ptc_pkg::WORD_W-1:0]   remaining_count,
	output logic      [ptc_pkg::WORD_W-1:0]   bcd_time_value
);
	import ptc_pkg::*;

	// ================================================================
	// Declarations.
	logic                   trig_q;       // Trigger level from software.
	logic                   kill_q;       // Kill level from software.
	logic                   ext_q;        // Selects extended_pulse_mode.
	logic                   trig_prev_q;  // Trigger one cycle earlier.
	logic                   kill_prev_q;  // Kill one cycle earlier.
	logic [13:0]            preload_q;    // Preload_value word.
	ptc_state_t             state_q;      // Running or idle.
	ptc_state_t             state_d;      // Next state.
	logic [READ_W-1:0]      reading_q;    // BCD reading.
	logic [READ_W-1:0]      reading_d;    // Next reading.
	logic [1:0]             base_q;       // Time base code.
	logic [1:0]             base_d;       // Next time base.
	logic                   load_en;      // Preload taken this cycle.
	logic                   trig_rise;    // Trigger rising edge.
	logic                   trig_fall;    // Trigger falling edge.
	logic                   kill_rise;    // Kill rising edge.
	logic [BASE_STAGES-1:0] tick;         // All base ticks.
	logic                   tick_sel;     // Tick of the held base.
	logic                   access;       // APB access phase.
	logic                   wr_en;        // Write completes now.
	logic                   mapped;       // Address is a register.
	logic [31:0]            rd_mux;       // Read data selection.

	// Refuse a prescaler the tick generator cannot serve.
	if (TICK_10MS_CYC < 2) begin : g_chk
		$error("TICK_10MS_CYC must be at least 2");
	end

	if (999 * 10 != MAX_DUR_S) begin : g_dur
		$error("three digits at 10 s must reach the longest duration");
	end

	// ================================================================
	// Helper functions.

	// Decrements a three-digit BCD value, stopping at zero.
	function automatic logic [READ_W-1:0] bcd_dec(input logic [READ_W-1:0] v);
		logic [READ_W-1:0] r;
		logic              borrow;
		r      = v;
		borrow = 1'b1;
		if (v != 12'h000) begin
			for (int d = 0; d < DIGITS; d++) begin
				if (borrow) begin
					if (v[d*4 +: 4] == 4'h0) begin
						r[d*4 +: 4] = 4'h9;
					end else begin
						r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
						borrow      = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction : bcd_dec

	// Clamps any non-decimal digit to nine.
	function automatic logic [READ_W-1:0] bcd_fix(input logic [READ_W-1:0] v);
		logic [READ_W-1:0] r;
		r = v;
		for (int d = 0; d < DIGITS; d++) begin
			if (v[d*4 +: 4] > 4'h9)
				r[d*4 +: 4] = 4'h9;
		end
		return r;
	endfunction : bcd_fix

	// ================================================================
	// Time base ticks.
	ptc_tick_gen #(
		.TICK_10MS_CYC (TICK_10MS_CYC)
	) u_tick (
		.sys_clk (sys_clk),
		.srst    (srst),
		.tick    (tick)
	);

	assign tick_sel = tick[base_q];

	// ================================================================
	// APB slave with one wait state.
	assign access = psel && penable;
	assign wr_en  = access && pready && pwrite;

	// Decodes the address and selects read data.
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0;
		case (paddr)
			OFS_CTRL:    rd_mux = {29'h0, ext_q, kill_q, trig_q};
			OFS_PRELOAD: rd_mux = {18'h0, preload_q};
			OFS_STATUS:  rd_mux = {31'h0, state_q == PT_RUN};
			OFS_TIME:    rd_mux = {16'h0, bcd_time_value};
			OFS_REMAIN:  rd_mux = {16'h0, remaining_count};
			default:     mapped = 1'b0;
		endcase
	end

	// Answers the second access cycle; data and error are captured before.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !mapped;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control register: trigger, kill and mode levels.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{ext_q, kill_q, trig_q} <= CTRL_RST;
		end else if (wr_en && paddr == OFS_CTRL) begin
			trig_q <= pwdata[CTRL_TRIG];
			kill_q <= pwdata[CTRL_KILL];
			ext_q  <= pwdata[CTRL_EXT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			preload_q <= PRELOAD_RST;
		else if (wr_en && paddr == OFS_PRELOAD)
			preload_q <= pwdata[13:0];
	end

	// ================================================================
	// Edge detection.

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trig_prev_q <= 1'b0;
			kill_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_q;
			kill_prev_q <= kill_q;
		end
	end
	assign trig_rise = trig_q && !trig_prev_q;
	assign trig_fall = !trig_q && trig_prev_q;
	assign kill_rise = kill_q && !kill_prev_q;

	// ================================================================
	// Timer next state.
	always_comb begin
		state_d   = state_q;
		reading_d = reading_q;
		base_d    = base_q;
		load_en   = 1'b0;
		case (state_q)
			PT_IDLE: begin
				if (trig_rise)
					load_en = 1'b1;
			end
			PT_RUN: begin
				if (kill_rise) begin
					reading_d = 12'h000;
					base_d    = BASE_10MS;
					state_d   = PT_IDLE;
				end else if (!ext_q && trig_fall) begin
					state_d = PT_IDLE;
				end else if (ext_q && trig_rise) begin
					load_en = 1'b1;
				end else if (tick_sel) begin
					reading_d = bcd_dec(reading_q);
					if (reading_q <= 12'h001)
						state_d = PT_IDLE;
				end
			end
			default: state_d = PT_IDLE;
		endcase
		if (load_en) begin
			// base from bits 12 and 13
			reading_d = bcd_fix(preload_q[READ_W-1:0]);
			base_d    = preload_q[BASE_HI:BASE_LO];
			// first interval may be partial, zero never runs
			state_d   = (bcd_fix(preload_q[READ_W-1:0]) != 12'h000) ? PT_RUN : PT_IDLE;
		end
	end

	// Timer registers and the pulse output.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q   <= PT_IDLE;
			reading_q <= 12'h000;
			base_q    <= BASE_10MS;
			pulse_out <= 1'b0;
		end else begin
			state_q   <= state_d;
			reading_q <= reading_d;
			base_q    <= base_d;
			pulse_out <= (state_d == PT_RUN);
		end
	end

	// ================================================================
	// Result outputs.

	always_ff @(posedge sys_clk) begin
		if (srst)
			bcd_time_value <= 16'h0000;
		else
			bcd_time_value <= {2'h0, base_q, reading_q};
	end

	ptc_bcd_bin u_bin (
		.sys_clk (sys_clk),
		.srst    (srst),
		.bcd     (reading_q),
		.bin_q   (remaining_count)
	);

	// ================================================================
	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	step_down_a: assert property (
		state_q == PT_RUN && tick_sel && !kill_rise && !load_en
		&& !(!ext_q && trig_fall)
		|=> reading_q == bcd_dec($past(reading_q)))
		else $error("reading did not drop one unit on tick");

	no_wrap_a: assert property (
		reading_q == 12'h000 && !load_en |=> reading_q == 12'h000)
		else $error("reading left zero without a load");

	edge_start_a: assert property (
		state_q == PT_IDLE && !trig_rise |=> state_q == PT_IDLE && !pulse_out)
		else $error("timer started without trigger rise");

	load_val_a: assert property (
		load_en |=> reading_q == bcd_fix($past(preload_q[READ_W-1:0]))
		&& base_q == $past(preload_q[BASE_HI:BASE_LO]))
		else $error("start did not load preload value");

	fall_stop_a: assert property (
		state_q == PT_RUN && !ext_q && trig_fall |=> !pulse_out ##1 !pulse_out)
		else $error("pulse stayed high after trigger fall");

	kill_clear_a: assert property (
		state_q == PT_RUN && kill_rise
		|=> reading_q == 12'h000 && base_q == BASE_10MS && !pulse_out)
		else $error("kill did not clear reading and base");

	kill_idle_a: assert property (
		state_q == PT_IDLE && kill_q && !trig_rise
		|=> $stable(reading_q) && $stable(base_q))
		else $error("kill changed an idle timer");

	pulse_run_a: assert property (
		pulse_out == (state_q == PT_RUN) && (state_q != PT_RUN || reading_q != 12'h000))
		else $error("pulse output differs from running state");

	retrig_a: assert property (
		state_q == PT_RUN && ext_q && trig_rise && !kill_rise
		|=> reading_q == bcd_fix($past(preload_q[READ_W-1:0])))
		else $error("retrigger did not reload count");

	hold_high_a: assert property (
		state_q == PT_RUN && ext_q && !kill_rise && !tick_sel && !trig_rise
		|=> pulse_out)
		else $error("extended pulse ended without expiry");

	// The last tick ends the pulse at the edge that zeroes the reading.
	expire_low_a: assert property (
		state_q == PT_RUN && tick_sel && reading_q == 12'h001 && !kill_rise && !load_en
		&& !(!ext_q && trig_fall)
		|=> !pulse_out && reading_q == 12'h000)
		else $error("pulse outlived the last tick");

endmodule : ptc_top
`default_nettype wire

//--- test/ptc_ctl_model.sv
/*
 Controlling-logic model: an APB master that writes trigger, kill and preload.
 Assumes the slave answers with pready on sys_clk; the bench bounds every wait.
*/
`timescale 1ns/1ps
`default_nettype none

module ptc_ctl_model (
	// Clock.
	input  wire logic                       sys_clk,
	// APB request side.
	output logic                            psel,
	output logic                            penable,
	output logic                            pwrite,
	output logic [ptc_pkg::APB_AW-1:0]      paddr,
	output logic [31:0]                     pwdata,
	// APB answer side.
	input  wire logic [31:0]                prdata,
	input  wire logic                       pready,
	input  wire logic                       pslverr
);
	import ptc_pkg::*;

	// ================================================================
	// Idle bus.
	// The bus starts released.
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// ================================================================
	// Transfers.
	// BCD preload word
	// One whole transfer; the caller supplies preload as BCD digits plus base.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Hold the request until pready is seen at an edge.
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released data no longer shows the old value.
		pwdata  <= ~d;
	endtask : xfer

endmodule : ptc_ctl_model

`default_nettype wire

//--- test/tb_top.sv
/*
 Self-checking bench of the pulse timer cell, one task per scenario.
 Assumes the design parameter TICK_10MS_CYC is shortened to ten cycles.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
	err_total++; $display("mismatch %s exp %h got %h", nm, exp, got); end end

module tb_top;
	import ptc_pkg::*;

	// ================================================================
	// Signals.
	logic        sys_clk = 1'b0;
	logic        srst    = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, pulse_out;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] remaining_count, bcd_time_value;
	logic        e;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;

	// Clock of 20 ns period.
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	ptc_top #(.TICK_10MS_CYC(10)) dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out),
		.remaining_count(remaining_count), .bcd_time_value(bcd_time_value));

	ptc_ctl_model ctl_u (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ================================================================
	// Helpers.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ctl_u.xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : step

	// Counts cycles of a high pulse_out, bounded.
	task automatic high_len(input int lim);
		n = 0;
		while (pulse_out === 1'b1 && n < lim) begin
			step(1);
			n++;
		end
	endtask : high_len

	// Closing report.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	// ================================================================
	// Scenarios.
	// Reset values of every register, then an unmapped read.
	task automatic s_reset();
		for (int i = 0; i < 5; i++) begin
			ctl_u.xfer(1'b0, 8'(i * 4), 32'h0, q, e);
			`CHK("reg reset", 32'h0, q)
		end
		ctl_u.xfer(1'b0, 8'h40, 32'h0, q, e);
		`CHK("unmapped err", 1'b1, e)
	endtask : s_reset

	// Largest reading at the slowest base, then kill while running.
	task automatic s_max();
		wr(OFS_PRELOAD, 32'h3999);
		wr(OFS_CTRL, 32'h1);
		step(2);
		`CHK("run pulse", 1'b1, pulse_out)
		`CHK("bcd max", 16'h3999, bcd_time_value)
		`CHK("bin max", 16'd999, remaining_count)
		`CHK("base bits", 2'h3, bcd_time_value[13:12])
		ctl_u.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
		`CHK("status run", 32'h1, q)
		ctl_u.xfer(1'b0, OFS_TIME, 32'h0, q, e);
		`CHK("time read", 32'h3999, q)
		wr(OFS_CTRL, 32'h3);
		step(2);
		`CHK("kill pulse", 1'b0, pulse_out)
		`CHK("kill bcd", 16'h0000, bcd_time_value)
		wr(OFS_CTRL, 32'h0);
	endtask : s_max

	// Full pulse at one base; length bounded, stops at zero, no restart.
	task automatic s_len(input logic [15:0] pre, input int lo, input int hi);
		wr(OFS_PRELOAD, {16'h0, pre});
		wr(OFS_CTRL, 32'h1);
		step(1);
		high_len(hi + 5);
		`CHK("pulse len", 1'b1, (n >= lo && n <= hi))
		step(1);
		`CHK("end count", 16'd0, remaining_count)
		step(40);
		`CHK("no wrap", 16'd0, remaining_count)
		`CHK("steady trig", 1'b0, pulse_out)
		wr(OFS_CTRL, 32'h0);
	endtask : s_len

	// Trigger fall aborts; kill while idle keeps the frozen reading.
	task automatic s_abort();
		wr(OFS_PRELOAD, 32'h1050);
		wr(OFS_CTRL, 32'h1);
		step(3);
		wr(OFS_CTRL, 32'h0);
		step(1);
		`CHK("abort pulse", 1'b0, pulse_out)
		wr(OFS_CTRL, 32'h2);
		step(3);
		`CHK("idle kill", 1'b1, (remaining_count >= 47 && remaining_count <= 50))
		`CHK("idle base", 16'h1000, bcd_time_value & 16'hff00)
		wr(OFS_CTRL, 32'h0);
	endtask : s_abort

	// Extended mode outlives the trigger and restarts on a new rise.
	task automatic s_ext();
		wr(OFS_CTRL, 32'h4);
		wr(OFS_PRELOAD, 32'h0004);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_CTRL, 32'h4);
		step(2);
		`CHK("ext hold", 1'b1, pulse_out)
		step(8);
		wr(OFS_CTRL, 32'h5);
		step(2);
		`CHK("reload", 16'd4, remaining_count)
		high_len(60);
		`CHK("ext len", 1'b1, (n >= 28 && n <= 41))
		wr(OFS_CTRL, 32'h0);
	endtask : s_ext

	// ================================================================
	// Main sequence and timeout.
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		s_reset();
		s_max();
		s_len(16'h0003, 19, 31);
		s_len(16'h1002, 99, 201);
		s_len(16'h2002, 999, 2001);
		s_abort();
		s_ext();
		end_of_test();
	end

	// A hang counts as a mismatch.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

endmodule : tb_top

`default_nettype wire
